// ==== src/tec_error_counters.v ====
// four saturating performance counters for one t1/e1 framer port, latched on a selectable update event
// assumes decoded per-bit event strobes from the line decoder and framer synchronizer, one clock domain
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "tec_regs.vh"

// Contract
// - latch all four counts on second, 42ms t1, 62.5ms e1, or manual update
// - every counter holds at maximum and never wraps to zero
// - port may update from shared first-port second tick or manual input
// - two successive same-polarity marks count as one bipolar violation
// - with zero substitution on, valid substitution codewords are not counted
// - e1 with select bit 0 set counts code violations instead of bipolar ones
// - line counter runs through every sync loss and stops at 65535
// - t1 excessive-zero mode adds 16-zero runs, or 8-zero runs with b8zs
// - t1 path counter: crc-6 in esf, ft errors in d4, fs added by bit 2
// - t1 path counter pauses while receive frame lost
// - e1 path counts crc-4 errors, pauses on fas/crc-4 loss, not cas loss
// - each counter reads as one 16-bit value, high part then low part
// - t1 multiframe mode counts out-of-sync multiframes, runs during frame loss
// - t1 framing-bit mode counts ft in d4 or fps in esf, pauses on loss
// - e1 sync counter counts fas word errors, not during loss or search
// - e1 crc-4 far-end counter adds one per received zero e-bit
// - far-end counter pauses on fas/crc-4 loss, runs on cas loss
// - automatic update pulses the timer interrupt output for software
module tec_error_counters #(
   parameter SECOND_CYC = `TEC_SECOND_CYC,
   parameter T1_CYC = `TEC_T1_CYC,
   parameter E1_CYC = `TEC_E1_CYC,
   parameter CNT_W = 16
) (
   input wire ref_clk,
   input wire reset_n,
   // axi4-lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // receive line decoder
   input wire rx_bit_valid,
   input wire rx_mark,
   input wire rx_mark_pos,
   input wire rx_zsub_code,
   // framer synchronizer
   input wire receive_frame_lost,
   input wire crc_sync_lost,
   input wire fas_searching,
   input wire multiframe_end,
   input wire crc_error,
   input wire ft_error,
   input wire fs_error,
   input wire fps_error,
   input wire fas_word_error,
   input wire ebit_valid,
   input wire ebit_value,
   // update sources
   input wire shared_second_tick,
   input wire manual_update,
   output reg timer_update_pulse,
   output reg own_second_tick
);

   // state overview:
   //   counter_config_r - count selects and update source, software owned
   //   mode_r - line mode, framing, zero substitution and crc-4 multiframe
   //   sec_cnt_r, short_cnt_r - free running interval timers
   //   *_cnt_r - live counts of the interval in progress
   //   *_lat_r - snapshot taken on the last update, what software sees
   //   last_pol_r, have_mark_r - polarity of the previous mark
   //   last_bpv_pol_r, have_bpv_r - polarity of the previous counted violation
   //   zrun_r - length of the zero run in progress
   //   upd_latched_r - sticky flag that a fresh snapshot is waiting
   wire rd_take;
   reg [4:0] counter_config_r;
   reg [3:0] mode_r;
   reg [31:0] sec_cnt_r;
   reg [31:0] short_cnt_r;
   reg [CNT_W-1:0] lcv_cnt_r, pcv_cnt_r, sync_cnt_r, feb_cnt_r;
   reg [CNT_W-1:0] lcv_lat_r, pcv_lat_r, sync_lat_r, feb_lat_r;
   reg manual_d_r;
   reg last_pol_r;
   reg have_mark_r;
   reg last_bpv_pol_r;
   reg have_bpv_r;
   reg [4:0] zrun_r;
   reg upd_latched_r;

   wire is_e1 = mode_r[`TEC_MODE_E1];
   wire is_esf = mode_r[`TEC_MODE_ESF];
   wire zsub_on = mode_r[`TEC_MODE_ZSUB];
   wire crc4_on = mode_r[`TEC_MODE_CRC4];
   wire [1:0] upd_sel = counter_config_r[`TEC_CFG_UPD_HI:`TEC_CFG_UPD_LO];
   wire [31:0] short_len = is_e1 ? E1_CYC : T1_CYC;
   wire sec_wrap = (sec_cnt_r == SECOND_CYC - 1);
   wire short_wrap = (short_cnt_r >= short_len - 1);
   wire manual_rise = manual_update & ~manual_d_r;
   reg update_evt;

   // the four sources are exclusive; only one can move the snapshot.
   // the short period follows the line mode, so a mode change sets the end
   // of the interval already in progress, without a restart of the timer.
   // the shared tick is used as delivered: it is already one cycle wide
   // from the first port, so no edge detect is put in its path.
   // a manual update is a level from outside; only its rising edge counts.
   // changing the source in mid interval simply lengthens or shortens that
   // one interval; no event is lost because the live counts keep running.
   // update event selection; the manual edge detect keeps a held input from latching twice
   always @* begin
      case (upd_sel)
         `TEC_UPD_SECOND: update_evt = sec_wrap;
         `TEC_UPD_SHORT: update_evt = short_wrap;
         `TEC_UPD_SHARED: update_evt = shared_second_tick;
         default: update_evt = manual_rise;
      endcase
   end

   // both timers always run, whatever the selected source, so that
   // own_second_tick stays available to other ports in every mode.
   // the short timer wraps with >= rather than == so that a switch from
   // the longer e1 period to the shorter t1 one cannot leave it running
   // past its end for a whole wrap of the 32-bit counter.
   // the timer pulse is registered, one cycle after the update edge, and
   // is held back for manual updates: software caused those itself.
   // own one-second and short-period timers
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sec_cnt_r <= 32'h00000000;
         short_cnt_r <= 32'h00000000;
         manual_d_r <= 1'b0;
         own_second_tick <= 1'b0;
         timer_update_pulse <= 1'b0;
      end else begin
         sec_cnt_r <= sec_wrap ? 32'h00000000 : sec_cnt_r + 32'h00000001;
         short_cnt_r <= short_wrap ? 32'h00000000 : short_cnt_r + 32'h00000001;
         manual_d_r <= manual_update;
         own_second_tick <= sec_wrap; // feeds other ports as the shared source
         timer_update_pulse <= update_evt && (upd_sel != `TEC_UPD_MANUAL);
      end
   end

   // every decode below is qualified by rx_bit_valid, so the polarity and
   // codeword inputs may wander freely between received bits.
   // a codeword mark is dropped from the violation count but still updates
   // the last polarity, since the next violation is judged against it.
   // a code violation needs two counted violations of one polarity; the
   // first one after reset only arms have_bpv_r.
   // a zero run counts once when it reaches its length, then starts again,
   // so a long all-zero stretch gives one count per full run.
   // line event decode: bipolar violation, code violation, zero runs
   wire bpv_raw = rx_bit_valid && rx_mark && have_mark_r && (rx_mark_pos == last_pol_r);
   wire bpv = bpv_raw && !(zsub_on && rx_zsub_code);
   wire cv = bpv && have_bpv_r && (rx_mark_pos == last_bpv_pol_r);
   wire [4:0] zlim = zsub_on ? `TEC_ZRUN_ZSUB : `TEC_ZRUN_PLAIN;
   wire zrun_hit = rx_bit_valid && !rx_mark && (zrun_r == zlim - 5'd1);
   wire lcv_evt = is_e1 ? (counter_config_r[`TEC_CFG_LCV_SEL] ? cv : bpv)
                        : (bpv || (counter_config_r[`TEC_CFG_LCV_SEL] && zrun_hit));

   // polarity and zero-run tracking
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         last_pol_r <= 1'b0;
         have_mark_r <= 1'b0;
         last_bpv_pol_r <= 1'b0;
         have_bpv_r <= 1'b0;
         zrun_r <= 5'd0;
      end else if (rx_bit_valid) begin
         if (rx_mark) begin
            last_pol_r <= rx_mark_pos;
            have_mark_r <= 1'b1;
            zrun_r <= 5'd0;
         end else if (zrun_hit) begin
            zrun_r <= 5'd0; // each full run counts once, then a new run starts
         end else begin
            zrun_r <= zrun_r + 5'd1;
         end
         if (bpv) begin
            last_bpv_pol_r <= rx_mark_pos;
            have_bpv_r <= 1'b1;
         end
      end
   end

   // the framer events arrive as one-cycle strobes; the pause conditions
   // are levels and gate the strobe in the same cycle.
   // in t1 the multiframe count runs only while frame is lost, which is
   // exactly when the framing-bit modes must stay quiet.
   // in e1 a cas multiframe loss is not an input here at all, so the path
   // and far-end counts carry on through it as required.
   // the far-end count exists only with crc-4 multiframing; in t1 or in
   // plain e1 it stays at zero.
   // path, sync and far-end events with their pause conditions
   wire t1_path = is_esf ? crc_error : (ft_error || (counter_config_r[`TEC_CFG_FS_SEL] && fs_error));
   wire pcv_evt = is_e1 ? (crc_error && !receive_frame_lost && !crc_sync_lost)
                        : (t1_path && !receive_frame_lost);
   wire t1_sync = counter_config_r[`TEC_CFG_FBIT_SEL]
                  ? ((is_esf ? fps_error : ft_error) && !receive_frame_lost)
                  : (multiframe_end && receive_frame_lost);
   wire sync_evt = is_e1 ? (fas_word_error && !receive_frame_lost && !fas_searching) : t1_sync;
   wire feb_evt = is_e1 && crc4_on && ebit_valid && !ebit_value
                  && !receive_frame_lost && !crc_sync_lost;

   // saturating increment; an update restarts from zero, keeping a same-cycle event
   function [CNT_W-1:0] sat_next;
      input [CNT_W-1:0] cur;
      input evt;
      input upd;
      begin
         if (upd)
            sat_next = evt ? {{(CNT_W-1){1'b0}}, 1'b1} : {CNT_W{1'b0}};
         else if (evt && cur != {CNT_W{1'b1}})
            sat_next = cur + {{(CNT_W-1){1'b0}}, 1'b1};
         else
            sat_next = cur;
      end
   endfunction

   // the live count and its snapshot move on the same edge: the snapshot
   // takes the old live value while the live count restarts, so an event
   // that falls on the update edge is kept for the next interval.
   // the snapshot holds until the next update, which lets software read
   // the high and low halves of one value with no torn read unless an update lands between the two reads.
   // the sticky flag gives a polled alternative to the timer pulse.
   // counters and latched copies
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lcv_cnt_r <= {CNT_W{1'b0}};
         pcv_cnt_r <= {CNT_W{1'b0}};
         sync_cnt_r <= {CNT_W{1'b0}};
         feb_cnt_r <= {CNT_W{1'b0}};
         lcv_lat_r <= {CNT_W{1'b0}};
         pcv_lat_r <= {CNT_W{1'b0}};
         sync_lat_r <= {CNT_W{1'b0}};
         feb_lat_r <= {CNT_W{1'b0}};
         upd_latched_r <= 1'b0;
      end else begin
         lcv_cnt_r <= sat_next(lcv_cnt_r, lcv_evt, update_evt);
         pcv_cnt_r <= sat_next(pcv_cnt_r, pcv_evt, update_evt);
         sync_cnt_r <= sat_next(sync_cnt_r, sync_evt, update_evt);
         feb_cnt_r <= sat_next(feb_cnt_r, feb_evt, update_evt);
         if (update_evt) begin
            lcv_lat_r <= lcv_cnt_r;
            pcv_lat_r <= pcv_cnt_r;
            sync_lat_r <= sync_cnt_r;
            feb_lat_r <= feb_cnt_r;
         end
         // sticky update flag: set wins over a read-clear in the same cycle
         if (update_evt)
            upd_latched_r <= 1'b1;
         else if (rd_take && s_axi_araddr == `TEC_STAT_OFS)
            upd_latched_r <= 1'b0;
      end
   end

   // axi4-lite write path: address and data taken together, either may come first
   reg aw_held_r, w_held_r;
   reg [7:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   wire aw_ok = aw_held_r || s_axi_awvalid;
   wire w_ok = w_held_r || s_axi_wvalid;
   wire [7:0] wa = aw_held_r ? aw_addr_r : s_axi_awaddr;
   wire [31:0] wd = w_held_r ? w_data_r : s_axi_wdata;
   wire [3:0] ws = w_held_r ? w_strb_r : s_axi_wstrb;
   wire wr_go = aw_ok && w_ok && !s_axi_bvalid;

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TEC_AXI_OKAY;
         counter_config_r <= `TEC_CFG_RESET;
         mode_r <= `TEC_MODE_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready && !wr_go) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !wr_go) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `TEC_AXI_OKAY;
            if (wa == `TEC_CFG_OFS) begin
               if (ws[0])
                  counter_config_r <= wd[4:0];
            end else if (wa == `TEC_MODE_OFS) begin
               if (ws[0])
                  mode_r <= wd[3:0];
            end else if (wa == `TEC_LCV_HI_OFS || wa == `TEC_LCV_LO_OFS || wa == `TEC_PCV_HI_OFS
                         || wa == `TEC_PCV_LO_OFS || wa == `TEC_SYNC_HI_OFS || wa == `TEC_SYNC_LO_OFS
                         || wa == `TEC_FEB_HI_OFS || wa == `TEC_FEB_LO_OFS || wa == `TEC_STAT_OFS) begin
               s_axi_bresp <= `TEC_AXI_OKAY; // read-only, write ignored
            end else begin
               s_axi_bresp <= `TEC_AXI_DECERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // reads never stall: arready is low only while an answer is waiting,
   // which also keeps one read outstanding at most.
   // counters are 16 bits but the bus reads them as two bytes; the high
   // byte is at the lower address so software reads it first.
   // unmapped addresses answer with a decode error and zero data.
   // reading the status word clears the sticky flag, except when an
   // update lands on that same edge.
   // axi4-lite read path: one-cycle answer, registered data
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_take = s_axi_arvalid && s_axi_arready;

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TEC_AXI_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `TEC_AXI_OKAY;
         s_axi_rdata <= 32'h00000000;
         if (s_axi_araddr == `TEC_CFG_OFS)
            s_axi_rdata <= {27'h0, counter_config_r};
         else if (s_axi_araddr == `TEC_MODE_OFS)
            s_axi_rdata <= {28'h0000000, mode_r};
         else if (s_axi_araddr == `TEC_LCV_HI_OFS)
            s_axi_rdata <= {24'h000000, lcv_lat_r[15:8]};
         else if (s_axi_araddr == `TEC_LCV_LO_OFS)
            s_axi_rdata <= {24'h000000, lcv_lat_r[7:0]};
         else if (s_axi_araddr == `TEC_PCV_HI_OFS)
            s_axi_rdata <= {24'h000000, pcv_lat_r[15:8]};
         else if (s_axi_araddr == `TEC_PCV_LO_OFS)
            s_axi_rdata <= {24'h000000, pcv_lat_r[7:0]};
         else if (s_axi_araddr == `TEC_SYNC_HI_OFS)
            s_axi_rdata <= {24'h000000, sync_lat_r[15:8]};
         else if (s_axi_araddr == `TEC_SYNC_LO_OFS)
            s_axi_rdata <= {24'h000000, sync_lat_r[7:0]};
         else if (s_axi_araddr == `TEC_FEB_HI_OFS)
            s_axi_rdata <= {24'h000000, feb_lat_r[15:8]};
         else if (s_axi_araddr == `TEC_FEB_LO_OFS)
            s_axi_rdata <= {24'h000000, feb_lat_r[7:0]};
         else if (s_axi_araddr == `TEC_STAT_OFS)
            s_axi_rdata <= {31'h0, upd_latched_r};
         else
            s_axi_rresp <= `TEC_AXI_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // tec_error_counters

// ==== shared/tec_regs.vh ====
// register offsets, field positions and timing figures of the error-counter block
// assumes an axi4-lite slave with 32-bit data, one register per aligned word
`ifndef TEC_REGS_VH
`define TEC_REGS_VH

// byte offsets of the registers
`define TEC_CFG_OFS 8'h00
`define TEC_MODE_OFS 8'h04
`define TEC_LCV_HI_OFS 8'h08
`define TEC_LCV_LO_OFS 8'h0C
`define TEC_PCV_HI_OFS 8'h10
`define TEC_PCV_LO_OFS 8'h14
`define TEC_SYNC_HI_OFS 8'h18
`define TEC_SYNC_LO_OFS 8'h1C
`define TEC_FEB_HI_OFS 8'h20
`define TEC_FEB_LO_OFS 8'h24
`define TEC_STAT_OFS 8'h28

// counter_config fields
`define TEC_CFG_LCV_SEL 0
`define TEC_CFG_FBIT_SEL 1
`define TEC_CFG_FS_SEL 2
`define TEC_CFG_UPD_LO 3
`define TEC_CFG_UPD_HI 4
`define TEC_CFG_RESET 5'h00

// update source encodings
`define TEC_UPD_SECOND 2'h0
`define TEC_UPD_SHORT 2'h1
`define TEC_UPD_SHARED 2'h2
`define TEC_UPD_MANUAL 2'h3

// mode register fields
`define TEC_MODE_E1 0
`define TEC_MODE_ESF 1
`define TEC_MODE_ZSUB 2
`define TEC_MODE_CRC4 3
`define TEC_MODE_RESET 4'h0

// timing figures
`define TEC_CLK_HZ 50000000
`define TEC_SECOND_MS 1000
`define TEC_T1_PERIOD_US 42000
`define TEC_E1_PERIOD_US 62500
`define TEC_SECOND_CYC (`TEC_CLK_HZ / 1000 * `TEC_SECOND_MS)
`define TEC_T1_CYC (`TEC_CLK_HZ / 1000000 * `TEC_T1_PERIOD_US)
`define TEC_E1_CYC (`TEC_CLK_HZ / 1000000 * `TEC_E1_PERIOD_US)

// zero-run lengths for excessive-zero counting
`define TEC_ZRUN_PLAIN 5'd16
`define TEC_ZRUN_ZSUB 5'd8

`define TEC_CNT_MAX 16'hFFFF
`define TEC_AXI_OKAY 2'h0
`define TEC_AXI_DECERR 2'h3

`endif

// ==== bench/tec_err_properties.sv ====
// bus and timer assertions for the error-counter block
// assumes it is bound into tec_error_counters, one clock domain
`timescale 1ns/10ps
`include "tec_regs.vh"
module tec_err_properties #(
   parameter SECOND_CYC = 100
) (
   input wire ref_clk,
   input wire reset_n,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire timer_update_pulse,
   input wire own_second_tick
);
   reg [31:0] gap_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // cycles since the last own tick; one spare for the registered pulse
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         gap_r <= 32'h0;
      else if (own_second_tick)
         gap_r <= 32'h0;
      else
         gap_r <= gap_r + 32'h1;
   end
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data moved");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response moved");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
   decerr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `TEC_AXI_DECERR |-> s_axi_rdata == 32'h0)
      else $error("decode error with data");
   timer_single_a: assert property (timer_update_pulse |=> !timer_update_pulse) else $error("long pulse");
   tick_single_a: assert property ($rose(own_second_tick) |=> !own_second_tick[*2]) else $error("long tick");
   second_period_a: assert property (gap_r <= SECOND_CYC + 1) else $error("second tick missing");
endmodule // tec_err_properties

bind tec_error_counters tec_err_properties #(.SECOND_CYC(SECOND_CYC)) chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .timer_update_pulse(timer_update_pulse), .own_second_tick(own_second_tick));

// ==== bench/tec_line_model.sv ====
// line decoder and framer synchronizer stand-in: event strobes plus qualifiers
// assumes ln bits 0..7 are strobes, 8..11 mark, polarity, codeword, e-bit value
`timescale 1ns/10ps
module tec_line_model (
   input wire logic ref_clk,
   output logic [11:0] ln
);
   logic [7:0] p_r = 8'h00;
   logic [3:0] v_r = 4'h0;
   logic tgl_r = 1'b0;
   // qualifiers mean nothing without a strobe, so they wander between strobes
   always @(posedge ref_clk) tgl_r <= ~tgl_r;
   assign ln = {(p_r[7] || p_r[5]) ? v_r : {4{tgl_r}}, p_r};
   // one strobe held for n cycles gives n events, never two on one counter per cycle
   task automatic burst(input int k, input logic [3:0] v, input int n);
      @(posedge ref_clk);
      p_r <= 8'h01 << k;
      v_r <= v;
      repeat (n) @(posedge ref_clk);
      p_r <= 8'h00;
   endtask
endmodule // tec_line_model

// ==== bench/tb_top.sv ====
// self-checking bench for the error counters: reads queued, answers checked by a monitor
// assumes the line model drives every decoder and framer strobe
`timescale 1ns/10ps
`include "tec_regs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
   logic ref_clk = 0, reset_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic man = 0, tick = 0, awready, wready, bvalid, arready, rvalid, tup, own;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic [2:0] lv = 3'h0;
   logic [11:0] ln;
   logic [33:0] q[$];
   logic [33:0] e;
   int n_fail = 0, n_compared = 0, cyc = 0, n;
   tec_line_model line (.ref_clk(ref_clk), .ln(ln));
   tec_error_counters #(.SECOND_CYC(100), .T1_CYC(40), .E1_CYC(60)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .rx_bit_valid(ln[7]), .rx_mark(ln[8]), .rx_mark_pos(ln[9]), .rx_zsub_code(ln[10]),
      .receive_frame_lost(lv[0]), .crc_sync_lost(lv[1]), .fas_searching(lv[2]), .multiframe_end(ln[6]),
      .crc_error(ln[0]), .ft_error(ln[1]), .fs_error(ln[2]), .fps_error(ln[3]), .fas_word_error(ln[4]),
      .ebit_valid(ln[5]), .ebit_value(ln[11]), .shared_second_tick(tick), .manual_update(man),
      .timer_update_pulse(tup), .own_second_tick(own));
   initial forever #10 ref_clk = ~ref_clk;
   // every read answer is matched against the oldest queued expectation
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 90000) begin
         n_fail++;
         print_verdict();
      end
      if (rvalid === 1'b1 && rready) begin
         e = q.pop_front();
         `CHK({rresp, rdata}, e)
      end
   end
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK(bresp, `TEC_AXI_OKAY)
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] x);
      @(posedge ref_clk);
      q.push_back(x);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask
   // a counter reads as high byte then low byte of one snapshot
   task automatic rc(input logic [7:0] a, input logic [15:0] v);
      rd(a, {26'h0, v[15:8]});
      rd(a + 8'h04, {26'h0, v[7:0]});
   endtask
   task automatic upd();
      @(posedge ref_clk);
      man <= 1'b1;
      repeat (3) @(posedge ref_clk);
      man <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic lvl(input logic [2:0] v);
      @(posedge ref_clk);
      lv <= v;
   endtask
   initial begin
      void'($urandom(37042));
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(`TEC_CFG_OFS, 34'h0);
      wr(`TEC_LCV_HI_OFS, 32'hFF);
      rc(`TEC_LCV_HI_OFS, 16'h0);
      rd(8'h40, {`TEC_AXI_DECERR, 32'h0});
      $display("test reset done");
      n = $urandom_range(20, 3);
      wr(`TEC_CFG_OFS, 32'h18);
      wr(`TEC_MODE_OFS, 32'h2);
      lvl(3'h1);
      line.burst(0, 4'h0, 5);
      lvl(3'h0);
      line.burst(0, 4'h0, n);
      line.burst(2, 4'h0, 3);
      upd();
      rc(`TEC_PCV_HI_OFS, n[15:0]);
      upd();
      rc(`TEC_PCV_HI_OFS, 16'h0);
      wr(`TEC_CFG_OFS, 32'h1C);
      wr(`TEC_MODE_OFS, 32'h0);
      line.burst(1, 4'h0, 2);
      line.burst(2, 4'h0, 3);
      lvl(3'h1);
      line.burst(6, 4'h0, 4);
      lvl(3'h0);
      upd();
      rc(`TEC_PCV_HI_OFS, 16'h5);
      rc(`TEC_SYNC_HI_OFS, 16'h4);
      rd(`TEC_STAT_OFS, 34'h1);
      rd(`TEC_STAT_OFS, 34'h0);
      wr(`TEC_CFG_OFS, 32'h1A);
      line.burst(1, 4'h0, 3);
      lvl(3'h1);
      line.burst(1, 4'h0, 2);
      lvl(3'h0);
      upd();
      rc(`TEC_SYNC_HI_OFS, 16'h3);
      rc(`TEC_PCV_HI_OFS, 16'h3);
      $display("test t1 path and sync done");
      // zero substitution on: ami would want plain bipolar counting instead
      wr(`TEC_CFG_OFS, 32'h18);
      wr(`TEC_MODE_OFS, 32'h4);
      line.burst(7, 4'h3, 1);
      line.burst(7, 4'h1, 1);
      upd();
      line.burst(7, 4'h3, 3);
      line.burst(7, 4'h5, 2);
      upd();
      rc(`TEC_LCV_HI_OFS, 16'h2);
      wr(`TEC_CFG_OFS, 32'h19);
      lvl(3'h7);
      line.burst(7, 4'h0, 8);
      lvl(3'h0);
      upd();
      rc(`TEC_LCV_HI_OFS, 16'h1);
      wr(`TEC_MODE_OFS, 32'h9);
      line.burst(7, 4'h3, 2);
      upd();
      line.burst(7, 4'h3, 2);
      line.burst(7, 4'h1, 2);
      upd();
      rc(`TEC_LCV_HI_OFS, 16'h2);
      $display("test line done");
      n = $urandom_range(20, 3);
      wr(`TEC_CFG_OFS, 32'h18);
      line.burst(5, 4'h0, n);
      line.burst(5, 4'h8, 3);
      lvl(3'h2);
      line.burst(5, 4'h0, 2);
      line.burst(0, 4'h0, 2);
      lvl(3'h0);
      line.burst(0, 4'h0, 4);
      line.burst(4, 4'h0, 3);
      lvl(3'h4);
      line.burst(4, 4'h0, 2);
      lvl(3'h0);
      upd();
      rc(`TEC_FEB_HI_OFS, n[15:0]);
      rc(`TEC_PCV_HI_OFS, 16'h4);
      rc(`TEC_SYNC_HI_OFS, 16'h3);
      $display("test e1 done");
      wr(`TEC_MODE_OFS, 32'h2);
      line.burst(0, 4'h0, 65540);
      upd();
      rc(`TEC_PCV_HI_OFS, 16'hFFFF);
      $display("test saturation done");
      wr(`TEC_CFG_OFS, 32'h08);
      wr(`TEC_MODE_OFS, 32'h0);
      do @(posedge ref_clk); while (tup !== 1'b1);
      line.burst(1, 4'h0, 3);
      do @(posedge ref_clk); while (tup !== 1'b1);
      rc(`TEC_PCV_HI_OFS, 16'h3);
      wr(`TEC_CFG_OFS, 32'h10);
      line.burst(1, 4'h0, 2);
      @(posedge ref_clk);
      tick <= 1'b1;
      @(posedge ref_clk);
      tick <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rc(`TEC_PCV_HI_OFS, 16'h2);
      $display("test update sources done");
      repeat (4) @(posedge ref_clk);
      print_verdict();
   end
endmodule // tb_top
